/* hdl/mil_intc.sv */
// Interrupt request latches, masking, priority and vector generation
//
// Contract
// - 25 sources, three non-maskable, rest maskable
// - Request sets latch, latch asks CPU
// - Maskable needs master and own flag
// - Pending maskables ordered by level, basic priority
// - Higher priority may nest inside service
// - Basic priorities: reset 1, NMI 2, 5..26
// - No order among NMIs (code offers traps before watchdog); traps share vector
// - Vector table top or relocated 0x01xx
// - Serial PROM option bytes never vectors
// - Latch per source except both traps
// - Latch cleared on accept and reset
// - Latches at 0x0FE0..0x0FE3, write zero clears
// - Watchdog and bit-two latch not clearable
// - Writing one never sets a latch
// - Latch reads show pending requests
// - Accept stacks and clears master flag
// - Master flag bit 0 at 0x003A, reset zero
// - Source accept flags reset to zero
// - Low latch bits 0..2 read zero
`default_nettype none
module mil_intc (
  input  wire logic        clk_in,          // System clock, 100 MHz
  input  wire logic        nrst_in,         // Asynchronous reset, active low
  input  wire logic [15:0] addr_in,         // Register address
  input  wire logic        wr_in,           // Register write strobe
  input  wire logic        rd_in,           // Register read strobe
  input  wire logic [7:0]  wdata_in,        // Register write data
  output logic      [7:0]  rdata_out,       // Register read data
  input  wire logic [25:3] src_req_in,      // Request pulses, watchdog and maskables
  input  wire logic        sw_trap_in,      // software_trap held until taken
  input  wire logic        bad_op_trap_in,  // bad_opcode_trap held until taken
  input  wire logic [43:0] level_in,        // Two-bit level per maskable source
  input  wire logic        vector_relocate_sel_in, // Relocate vectors to 0x01xx
  input  wire logic        accept_in,       // Core takes the offered request
  input  wire logic        return_in,       // Return instruction restores flag
  output logic             irq_out,         // Request offered to core
  output logic      [15:0] vector_out,      // Vector of offered request
  output logic      [1:0]  kind_out,        // Kind of offered request
  output logic             master_accept_flag_out // Current master flag
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [25:0]         lat;     // Request latches
    logic [25:0]         ef;      // Source accept flags
    logic                master_accept_flag;     // Master accept flag
    logic [7:0]          stk;     // Stacked master flags, bit 0 newest
    logic [7:0]          rdata;   // Read data register
    logic                irq;     // Offered request
    logic [15:0]         vector;  // Offered vector
    mil_pkg::mil_kind_e  kind;    // Offered kind
    logic [4:0]          idx;     // Offered latch index
  } mil_state_s;

  mil_state_s st;       // Registered state
  mil_state_s next_st;  // Next state

  // ==========================================================
  // Functions
  // Pick pending maskable with highest level, lowest index on tie
  function automatic logic [5:0] mil_pick(input logic [25:0] pend,
                                          input logic [43:0] lvl);
    logic       found;
    logic [4:0] best_idx;
    logic [1:0] best_lvl;
    found    = 1'b0;
    best_idx = 5'h00;
    best_lvl = 2'h0;
    for (int i = mil_pkg::FIRST_MASK; i <= mil_pkg::LAST_MASK; i++) begin
      // Strictly greater keeps the lower index on a tie
      if (pend[i] && (!found || lvl[2*(i-mil_pkg::FIRST_MASK) +: 2] > best_lvl)) begin
        found    = 1'b1;
        best_idx = 5'(i);
        best_lvl = lvl[2*(i-mil_pkg::FIRST_MASK) +: 2];
      end
    end
    return {found, best_idx};
  endfunction : mil_pick

  // Vector of a request; never yields the option byte pair
  function automatic logic [15:0] mil_vec(input mil_pkg::mil_kind_e k,
                                          input logic [4:0] idx,
                                          input logic reloc);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = reloc ? mil_pkg::VEC_LOW_HI : mil_pkg::VEC_TOP_HI;
    lo = mil_pkg::VEC_MASK_LO - 8'({idx - 5'(mil_pkg::FIRST_MASK), 1'b0});
    case (k)
      mil_pkg::MIL_TRAP: return {hi, mil_pkg::VEC_TRAP_LO};
      mil_pkg::MIL_WDT:  return {hi, mil_pkg::VEC_WDT_LO};
      mil_pkg::MIL_MASK: return {hi, lo};
      default:           return mil_pkg::VEC_RESET;
    endcase
  endfunction : mil_vec

  // ==========================================================
  // Combinational next state
  always_comb begin
    logic [25:0] set_mask;   // Requests arriving this cycle
    logic [25:0] clr_mask;   // Bits cleared by software or acceptance
    logic [25:0] pend;       // Enabled maskable pending requests
    logic [5:0]  pick;       // Arbitration result
    mil_pkg::mil_kind_e k;   // Kind chosen this cycle
    set_mask = {src_req_in, 3'b000};
    clr_mask = 26'h000_0000;
    pend     = 26'h000_0000;
    pick     = 6'h00;
    k        = mil_pkg::MIL_NONE;
    next_st  = st;

    // Software clears: a zero bit clears, a one leaves the latch alone
    if (wr_in) begin
      case (addr_in)
        mil_pkg::ADDR_LAT_LOW:  clr_mask[7:0]   = ~wdata_in & mil_pkg::LOW_LAT_MASK;
        mil_pkg::ADDR_LAT_HIGH: clr_mask[15:8]  = ~wdata_in;
        mil_pkg::ADDR_LAT_EXT:  clr_mask[23:16] = ~wdata_in;
        mil_pkg::ADDR_LAT_TOP:  clr_mask[25:24] = ~wdata_in[1:0];
        mil_pkg::ADDR_ACC_LOW: begin
          next_st.ef[7:4] = wdata_in[7:4];
          next_st.master_accept_flag     = wdata_in[mil_pkg::IMF_BIT];
        end
        mil_pkg::ADDR_ACC_HIGH: next_st.ef[15:8]  = wdata_in;
        mil_pkg::ADDR_ACC_EXT:  next_st.ef[23:16] = wdata_in;
        mil_pkg::ADDR_ACC_TOP:  next_st.ef[25:24] = wdata_in[1:0];
        default: ;                                          // Unmapped writes ignored
      endcase
    end

    // Acceptance of the offered request
    if (accept_in && st.irq) begin
      next_st.stk = {st.stk[6:0], st.master_accept_flag};
      next_st.master_accept_flag = 1'b0;
      if (st.kind == mil_pkg::MIL_WDT || st.kind == mil_pkg::MIL_MASK) begin
        clr_mask[st.idx] = 1'b1;
      end
    end else if (return_in) begin
      // Return pops the stacked master flag
      next_st.master_accept_flag = st.stk[0];
      next_st.stk = {1'b0, st.stk[7:1]};
    end

    // New requests win over any clear in the same cycle
    next_st.lat = (st.lat & ~clr_mask) | set_mask;

    // Arbitration: traps, then watchdog, then maskable
    pend = st.lat & st.ef & {26{st.master_accept_flag}};
    pick = mil_pick(pend, level_in);
    if (sw_trap_in || bad_op_trap_in) begin
      k = mil_pkg::MIL_TRAP;
    end else if (st.lat[mil_pkg::WDT_BIT]) begin
      k = mil_pkg::MIL_WDT;
    end else if (pick[5]) begin
      k = mil_pkg::MIL_MASK;
    end else begin
      k = mil_pkg::MIL_NONE;
    end
    // Hold off a fresh offer in the accept cycle so it is not taken twice
    if (accept_in && st.irq) begin
      k = mil_pkg::MIL_NONE;
    end
    next_st.kind   = k;
    next_st.irq    = (k != mil_pkg::MIL_NONE);
    next_st.idx    = (k == mil_pkg::MIL_WDT) ? 5'(mil_pkg::WDT_BIT) : pick[4:0];
    next_st.vector = mil_vec(k, next_st.idx, vector_relocate_sel_in);

    // Read data; unused bits read zero
    if (rd_in) begin
      case (addr_in)
        mil_pkg::ADDR_LAT_LOW:  next_st.rdata = st.lat[7:0] & 8'hf8;
        mil_pkg::ADDR_LAT_HIGH: next_st.rdata = st.lat[15:8];
        mil_pkg::ADDR_LAT_EXT:  next_st.rdata = st.lat[23:16];
        mil_pkg::ADDR_LAT_TOP:  next_st.rdata = {6'h00, st.lat[25:24]};
        mil_pkg::ADDR_ACC_LOW:  next_st.rdata = {st.ef[7:4], 3'b000, st.master_accept_flag};
        mil_pkg::ADDR_ACC_HIGH: next_st.rdata = st.ef[15:8];
        mil_pkg::ADDR_ACC_EXT:  next_st.rdata = st.ef[23:16];
        mil_pkg::ADDR_ACC_TOP:  next_st.rdata = {6'h00, st.ef[25:24]};
        default:                next_st.rdata = 8'h00;                 // Unmapped reads zero
      endcase
    end
    // Positions without a source never hold a request
    next_st.lat[2:0] = 3'b000;
    next_st.ef[3:0]  = 4'h0;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st.lat    <= mil_pkg::LAT_RESET;
      st.ef     <= mil_pkg::EF_RESET;
      st.master_accept_flag    <= mil_pkg::IMF_RESET;
      st.stk    <= mil_pkg::STACK_RESET;
      st.rdata  <= 8'h00;
      st.irq    <= 1'b0;
      st.vector <= mil_pkg::VEC_RESET;
      st.kind   <= mil_pkg::MIL_NONE;
      st.idx    <= 5'h00;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_out              = st.rdata;
  assign irq_out                = st.irq;
  assign vector_out             = st.vector;
  assign kind_out               = st.kind;
  assign master_accept_flag_out = st.master_accept_flag;

  // ==========================================================
  // Assertions
  default clocking mil_cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // Core takes a maskable request
  sequence s_take_mask;
    accept_in && st.irq && st.kind == mil_pkg::MIL_MASK;
  endsequence
  // Core returns from a handler with no accept
  sequence s_return;
    return_in && !(accept_in && st.irq);
  endsequence

  a_accept_clears_imf: assert property (s_take_mask |=> !st.master_accept_flag && st.stk[0] == $past(st.master_accept_flag))
    else $error("Master flag not stacked and cleared on accept");
  a_return_restores: assert property (s_return |=> st.master_accept_flag == $past(st.stk[0]))
    else $error("Master flag not restored on return");
  a_mask_needs_flags: assert property (next_st.kind == mil_pkg::MIL_MASK |-> st.master_accept_flag
      && st.ef[next_st.idx])
    else $error("Maskable offered without both accept flags");
  a_latch_clear_ack: assert property ((s_take_mask ##0 !src_req_in[st.idx])
      |=> !st.lat[$past(st.idx)])
    else $error("Accepted latch not cleared");
  a_write_one_keeps: assert property ((wr_in && addr_in == mil_pkg::ADDR_LAT_HIGH
      && wdata_in == 8'hff && !accept_in && src_req_in[15:8] == 8'h00)
      |=> st.lat[15:8] == $past(st.lat[15:8]))
    else $error("Write of ones changed latches");
  a_wdt_not_clear: assert property ($past(st.lat[mil_pkg::WDT_BIT]) && !$past(accept_in)
      |-> st.lat[mil_pkg::WDT_BIT])
    else $error("Watchdog latch cleared without accept");
  a_low_reads_zero: assert property (rd_in && addr_in == mil_pkg::ADDR_LAT_LOW
      |=> rdata_out[2:0] == 3'b000 && rdata_out[7:3] == $past(st.lat[7:3]))
    else $error("Low latch read wrong");
  a_request_sets: assert property (src_req_in[9] |=> st.lat[9])
    else $error("Request did not set latch");
  a_trap_vector: assert property (sw_trap_in && !(accept_in && st.irq)
      |=> vector_out[7:0] == mil_pkg::VEC_TRAP_LO && irq_out)
    else $error("Trap vector wrong");
  a_vector_page: assert property (st.irq |-> vector_out[15:8] ==
      ($past(vector_relocate_sel_in) ? mil_pkg::VEC_LOW_HI : mil_pkg::VEC_TOP_HI))
    else $error("Vector page wrong");

  // ==========================================================
  // Further guards on offers, latches and the flag stack

  // Core takes whatever request is offered
  sequence s_take_any;
    accept_in && st.irq;
  endsequence

  // Offer drops after being taken, so it is never taken twice
  a_offer_drops: assert property (s_take_any |=> !irq_out)
    else $error("Offer stood after accept");

  // Option byte pair never appears as a vector
  a_option_bytes: assert property (irq_out |->
      vector_out[15:1] != mil_pkg::OPT_CODE_LO[15:1])
    else $error("Option byte pair offered as vector");

  // Maskable vectors are even and at or below the first slot
  a_mask_vector: assert property (st.kind == mil_pkg::MIL_MASK |->
      vector_out[0] == 1'b0 && vector_out[7:0] <= mil_pkg::VEC_MASK_LO)
    else $error("Maskable vector out of table");

  // Watchdog has its own fixed slot
  a_wdt_vector: assert property (st.kind == mil_pkg::MIL_WDT |->
      vector_out[7:0] == mil_pkg::VEC_WDT_LO)
    else $error("Watchdog vector wrong");

  // Idle offer shows the reset vector
  a_vector_idle: assert property (!st.irq |-> vector_out == mil_pkg::VEC_RESET)
    else $error("Idle vector wrong");

  // A request beats a software clear in the same cycle
  a_set_beats_clear: assert property ((wr_in && addr_in == mil_pkg::ADDR_LAT_HIGH
      && src_req_in[8]) |=> st.lat[8])
    else $error("Clear won over a new request");

  // A zero bit written clears its latch
  a_zero_clears: assert property ((wr_in && addr_in == mil_pkg::ADDR_LAT_EXT
      && !wdata_in[0] && !src_req_in[16]) |=> !st.lat[16])
    else $error("Written zero did not clear latch");

  // Positions without a source stay empty
  a_no_spare_latch: assert property (st.lat[2:0] == 3'b000)
    else $error("Spare latch position set");

  // Non-maskable positions carry no accept flag
  a_spare_flags: assert property (st.ef[3:0] == 4'h0)
    else $error("Accept flag on non-maskable position");

  // Offer line and offered kind agree
  a_kind_irq: assert property (irq_out == (st.kind != mil_pkg::MIL_NONE))
    else $error("Offer and kind disagree");

  // A pending watchdog is offered ahead of maskables
  a_watchdog_first: assert property ((st.lat[mil_pkg::WDT_BIT] && !sw_trap_in
      && !bad_op_trap_in && !(accept_in && st.irq)) |=> st.kind == mil_pkg::MIL_WDT)
    else $error("Watchdog not offered");

  // A trap request is offered whatever the flags
  a_trap_first: assert property (((sw_trap_in || bad_op_trap_in)
      && !(accept_in && st.irq)) |=> st.kind == mil_pkg::MIL_TRAP)
    else $error("Trap not offered");

  // Accept pushes the flag stack one deeper for nesting
  a_nest_push: assert property (s_take_any |=> st.stk[7:1] == $past(st.stk[6:0]))
    else $error("Flag stack not pushed");

  // Return pops the flag stack
  a_pop_shift: assert property (s_return |=>
      st.stk[6:0] == $past(st.stk[7:1]) && !st.stk[7])
    else $error("Flag stack not popped");

  // Accept flag byte takes the written value
  a_ef_write: assert property (wr_in && addr_in == mil_pkg::ADDR_ACC_HIGH
      |=> st.ef[15:8] == $past(wdata_in))
    else $error("Accept flags not written");

  // High latch byte reads back the pending state
  a_read_high: assert property (rd_in && addr_in == mil_pkg::ADDR_LAT_HIGH
      |=> rdata_out == $past(st.lat[15:8]))
    else $error("High latch read wrong");

  // Unimplemented top latch bits read zero
  a_read_top: assert property (rd_in && addr_in == mil_pkg::ADDR_LAT_TOP
      |=> rdata_out[7:2] == 6'h00)
    else $error("Top latch read wrong");
endmodule : mil_intc
`default_nettype wire

/* hdl/mil_pkg.sv */
// Constants shared by the interrupt latch and priority controller
`default_nettype none
package mil_pkg;
  // ==========================================================
  // Source counts and layout
  localparam int          NUM_SOURCES   = 25;         // Sources besides reset
  localparam int          LATCH_BITS    = 26;         // Latch positions 0..25
  localparam int          FIRST_MASK    = 4;          // First maskable index
  localparam int          LAST_MASK     = 25;         // Last maskable index
  localparam int          NUM_MASK      = 22;         // Maskable source count
  localparam int          LEVEL_W       = 2;          // Priority level width
  localparam int          WDT_BIT       = 3;          // Watchdog latch index
  localparam int          STACK_DEPTH   = 8;          // Stacked master flags
  // ==========================================================
  // Special function register addresses
  localparam logic [15:0] ADDR_LAT_LOW  = 16'h0fe0;   // request_latch_low
  localparam logic [15:0] ADDR_LAT_HIGH = 16'h0fe1;   // request_latch_high
  localparam logic [15:0] ADDR_LAT_EXT  = 16'h0fe2;   // request_latch_ext
  localparam logic [15:0] ADDR_LAT_TOP  = 16'h0fe3;   // request_latch_top
  localparam logic [15:0] ADDR_ACC_LOW  = 16'h003a;   // accept_reg_low
  localparam logic [15:0] ADDR_ACC_HIGH = 16'h003b;   // accept_reg_high
  localparam logic [15:0] ADDR_ACC_EXT  = 16'h003c;   // accept_reg_ext
  localparam logic [15:0] ADDR_ACC_TOP  = 16'h003d;   // accept_reg_top
  // ==========================================================
  // Field positions and masks
  localparam int          IMF_BIT       = 0;          // Master flag in accept_reg_low
  localparam logic [7:0]  LOW_LAT_MASK  = 8'hf0;      // Clearable bits, low latch
  localparam logic [7:0]  LOW_ACC_MASK  = 8'hf1;      // Writable bits, accept low
  localparam logic [7:0]  TOP_MASK      = 8'h03;      // Implemented bits, top byte
  // ==========================================================
  // Reset values
  localparam logic [25:0] LAT_RESET     = 26'h000_0000; // All latches clear
  localparam logic [25:0] EF_RESET      = 26'h000_0000; // All sources masked
  localparam logic        IMF_RESET     = 1'b0;          // Master flag clear
  localparam logic [7:0]  STACK_RESET   = 8'h00;         // Empty flag stack
  // ==========================================================
  // Vector addresses
  localparam logic [15:0] VEC_RESET     = 16'hfffe;   // Reset vector
  localparam logic [7:0]  VEC_TRAP_LO   = 8'hfc;      // Shared trap vector
  localparam logic [7:0]  VEC_WDT_LO    = 8'hf8;      // Watchdog vector
  localparam logic [7:0]  VEC_MASK_LO   = 8'hf6;      // First maskable vector
  localparam logic [7:0]  VEC_TOP_HI    = 8'hff;      // Page in top of ROM
  localparam logic [7:0]  VEC_LOW_HI    = 8'h01;      // Relocated page
  localparam logic [15:0] OPT_CODE_LO   = 16'hfffa;   // Option byte pair, never a vector
  // ==========================================================
  // Fixed basic priorities
  localparam int          PRIO_RESET    = 1;
  localparam int          PRIO_NMI      = 2;
  localparam int          PRIO_MASK0    = 5;          // Ranks 5..26
  // ==========================================================
  // Kind of the request offered to the core
  typedef enum logic [1:0] {
    MIL_NONE,
    MIL_TRAP,
    MIL_WDT,
    MIL_MASK
  } mil_kind_e;
endpackage : mil_pkg
`default_nettype wire

/* tb/mil_core_model.sv */
// Behavioural core that accepts offered interrupts and runs returns
`default_nettype none
module mil_core_model (
  input  wire logic        clk_in,       // System clock
  input  wire logic        nrst_in,      // Reset, active low
  input  wire logic        take_en_in,   // Core may accept
  input  wire logic        slow_in,      // Stall before accepting
  input  wire logic        ret_req_in,   // Execute a return
  input  wire logic        irq_in,       // Offered request
  input  wire logic [15:0] vector_in,    // Offered vector
  output logic             accept_out,   // Accept pulse
  output logic             return_out,   // Return pulse
  output logic      [15:0] taken_vec_out // Vector last taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold_q; // Cycles the offer has stood
  // ==========================================
  // Accept after the offer stood long enough
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      accept_out    <= 1'b0;
      return_out    <= 1'b0;
      taken_vec_out <= 16'h0000;
      hold_q        <= 3'h0;
    end else begin
      return_out <= ret_req_in;
      accept_out <= 1'b0;
      if (!take_en_in || !irq_in || accept_out) begin
        hold_q <= 3'h0;
      end else if (hold_q == (slow_in ? 3'h4 : 3'h0)) begin
        accept_out    <= 1'b1;
        taken_vec_out <= vector_in;
      end else begin
        hold_q <= hold_q + 3'h1;
      end
    end
  end
endmodule : mil_core_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the interrupt latch and priority controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [25:3] src = '0;
  logic        sw_trap = 1'b0;
  logic        bad_trap = 1'b0;
  logic [43:0] level = '0;
  logic        reloc = 1'b0;
  logic        take_en = 1'b0;
  logic        slow = 1'b0;
  logic        ret_req = 1'b0;
  logic [7:0]  rdata;
  logic        accept, ret, irq, mflag;
  logic [15:0] vector, taken;
  logic [1:0]  kind;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cycles = 0;
  always #5 clk_in = ~clk_in;
  mil_intc i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr), .wr_in(wr),
    .rd_in(rd), .wdata_in(wdata), .rdata_out(rdata), .src_req_in(src),
    .sw_trap_in(sw_trap), .bad_op_trap_in(bad_trap), .level_in(level),
    .vector_relocate_sel_in(reloc), .accept_in(accept), .return_in(ret), .irq_out(irq),
    .vector_out(vector), .kind_out(kind), .master_accept_flag_out(mflag));
  mil_core_model i_core (.clk_in(clk_in), .nrst_in(nrst_in), .take_en_in(take_en),
    .slow_in(slow), .ret_req_in(ret_req), .irq_in(irq), .vector_in(vector),
    .accept_out(accept), .return_out(ret), .taken_vec_out(taken));
  // ==========================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 check("read", {8'h00, rdata}, {8'h00, exp});
  endtask : rd_chk
  task automatic pulse(input int i);
    @(posedge clk_in);
    src <= 23'h1 << (i - 3);
    @(posedge clk_in);
    src <= '0;
  endtask : pulse
  task automatic offer(input logic on, input logic [15:0] v, input logic [1:0] k);
    repeat (2) @(posedge clk_in);
    #1 check("irq", {15'h0, irq}, {15'h0, on});
    if (on) begin
      check("vector", vector, v);
      check("kind", {14'h0, kind}, {14'h0, k});
    end
  endtask : offer
  task automatic take(input logic [15:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      #1 n++;
    end while (accept !== 1'b1 && n < 60);
    @(posedge clk_in);
    sw_trap  <= 1'b0;
    bad_trap <= 1'b0;
    #1 check("taken vector", taken, exp);
    check("master flag", {15'h0, mflag}, 16'h0000);
  endtask : take
  task automatic ret_pulse();
    @(posedge clk_in);
    ret_req <= 1'b1;
    @(posedge clk_in);
    ret_req <= 1'b0;
    @(posedge clk_in);
    #1 check("restored flag", {15'h0, mflag}, 16'h0001);
  endtask : ret_pulse
  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    offer(1'b0, 16'hfffe, 2'd0);
    check("reset vector", vector, 16'hfffe);
    for (int a = 0; a < 4; a++) begin
      rd_chk(16'h0fe0 + 16'(a), 8'h00);
      rd_chk(16'h003a + 16'(a), 8'h00);
    end
    rd_chk(16'h0123, 8'h00);
    // Every maskable pends while masked
    @(posedge clk_in);
    src <= 23'h7f_fffe;
    @(posedge clk_in);
    src <= '0;
    offer(1'b0, 16'h0000, 2'd0);
    rd_chk(16'h0fe0, 8'hf0);
    rd_chk(16'h0fe1, 8'hff);
    rd_chk(16'h0fe2, 8'hff);
    rd_chk(16'h0fe3, 8'h03);
    wr_reg(16'h0fe1, 8'hfe);
    rd_chk(16'h0fe1, 8'hfe);
    for (int a = 0; a < 4; a++) begin
      wr_reg(16'h0fe0 + 16'(a), 8'h00);
      wr_reg(16'h0fe0 + 16'(a), 8'hff);
      rd_chk(16'h0fe0 + 16'(a), 8'h00);
    end
    // Master and own flag both needed
    pulse(9);
    wr_reg(16'h003b, 8'hff);
    offer(1'b0, 16'h0000, 2'd0);
    wr_reg(16'h003a, 8'h01);
    offer(1'b1, 16'hffec, 2'd3);
    wr_reg(16'h003b, 8'h00);
    offer(1'b0, 16'h0000, 2'd0);
    wr_reg(16'h003a, 8'h00);
    wr_reg(16'h0fe1, 8'h00);
    // Watchdog latch ignores flags and writes
    pulse(3);
    offer(1'b1, 16'hfff8, 2'd2);
    wr_reg(16'h0fe0, 8'h00);
    rd_chk(16'h0fe0, 8'h08);
    wr_reg(16'h003a, 8'h01);
    @(posedge clk_in);
    take_en <= 1'b1;
    take(16'hfff8);
    rd_chk(16'h0fe0, 8'h00);
    ret_pulse();
    // Both traps share one vector, top and relocated
    for (int t = 0; t < 4; t++) begin
      @(posedge clk_in);
      reloc    <= t[1];
      slow     <= t[0];
      sw_trap  <= !t[0];
      bad_trap <= t[0];
      take(t[1] ? 16'h01fc : 16'hfffc);
      ret_pulse();
    end
    // Each maskable vector, alternating area
    wr_reg(16'h003a, 8'hf1);
    wr_reg(16'h003b, 8'hff);
    wr_reg(16'h003c, 8'hff);
    wr_reg(16'h003d, 8'h03);
    for (int i = 4; i < 26; i++) begin
      @(posedge clk_in);
      reloc <= i[0];
      pulse(i);
      take({i[0] ? 8'h01 : 8'hff, 8'hf6 - 8'(2 * (i - 4))});
      ret_pulse();
    end
    // Level first, then basic priority
    @(posedge clk_in);
    take_en <= 1'b0;
    reloc   <= 1'b0;
    level   <= 44'h003_0000_1050; // 20:3, 10:1, 7:1, 6:1
    pulse(20);
    pulse(6);
    pulse(7);
    pulse(10);
    @(posedge clk_in);
    take_en <= 1'b1;
    slow    <= 1'b1;
    take(16'hffd6);
    ret_pulse();
    take(16'hfff2);
    ret_pulse();
    take(16'hfff0);
    ret_pulse();
    take(16'hffea);
    ret_pulse();
    // Nesting inside a service routine
    pulse(11);
    take(16'hffe8);
    wr_reg(16'h003a, 8'hf1);
    pulse(5);
    take(16'hfff4);
    ret_pulse();
    ret_pulse();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
